/* verilog/profile_pkg.sv */
// Constants, modes and carriers shared by the speed-profile generator.
// Assumes one 10 MHz clock; all times in ms, all speeds in kilo-steps/min.
package profile_pkg;

  // Clock and control tick
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Data widths and fixed point (speed is 16.16 inside)
  localparam int SPD_W  = 16;
  localparam int FX_W   = 32;
  localparam int FRAC_W = 16;
  localparam int MA_AW  = 10;
  localparam logic [10:0] MA_DEPTH = 11'h400;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_TGT    = 8'h08;
  localparam logic [7:0] OFF_ACC    = 8'h0c;
  localparam logic [7:0] OFF_DEC    = 8'h10;
  localparam logic [7:0] OFF_SWSPD  = 8'h14;
  localparam logic [7:0] OFF_ACC2   = 8'h18;
  localparam logic [7:0] OFF_EXPTC  = 8'h1c;
  localparam logic [7:0] OFF_BIAS   = 8'h20;
  localparam logic [7:0] OFF_MATC   = 8'h24;
  localparam logic [7:0] OFF_MAX    = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  localparam logic [7:0] OFF_SPEED  = 8'h30;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int MODE_RAMP_LSB  = 0;
  localparam int MODE_FILT_LSB  = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DECEL_BIT = 1;

  // Ramp-type and filter-select codes
  typedef enum logic [1:0] {
    RAMP_NONE   = 2'h0,
    RAMP_SINGLE = 2'h1,
    RAMP_DOUBLE = 2'h2,
    RAMP_ASYM   = 2'h3
  } ramp_e;

  typedef enum logic [1:0] {
    FILT_NONE     = 2'h0,
    FILT_EXP      = 2'h1,
    FILT_EXP_BIAS = 2'h2,
    FILT_MAVG     = 2'h3
  } filt_e;

  // Profile parameter set, all reset to zero
  typedef struct packed {
    logic [15:0] target_speed;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
    logic [15:0] step_change_speed;
    logic [15:0] second_accel_time;
    logic [15:0] exp_time_constant;
    logic [15:0] bias_speed;
    logic [15:0] moving_avg_time_constant;
    logic [15:0] max_speed_limit;
    ramp_e       ramp_type_code;
    filt_e       filter_select_code;
  } params_s;
  localparam params_s PARAM_RST = '0;

  // Generator sequence, Gray along the tick loop except ST_WAIT to ST_MARD
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_WAIT  = 3'h3,
    ST_EXP   = 3'h2,
    ST_MARD  = 3'h6,
    ST_MADIV = 3'h7
  } gen_state_e;

endpackage : profile_pkg

/* verilog/div_unit.sv */
// Sequential restoring divider, 32-bit dividend by 16-bit divisor.
// Assumes start is a pulse while idle; result after 32 cycles.
module div_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  output logic      [31:0] quotient,
  output logic             done
);
  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] q;
    logic [15:0] rem;
    logic [15:0] dvs;
    logic        done;
  } div_s;

  div_s        s_r;
  div_s        s_nxt;
  logic [16:0] rem_sh;

  // One quotient bit per cycle; divide by zero gives all ones
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    rem_sh     = {s_r.rem, s_r.q[31]};
    if (start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = 6'h00;
      s_nxt.q    = dividend;
      s_nxt.rem  = 16'h0000;
      s_nxt.dvs  = divisor;
    end else if (s_r.busy) begin
      if (rem_sh >= {1'b0, s_r.dvs}) begin
        s_nxt.rem = 16'(rem_sh - {1'b0, s_r.dvs});
        s_nxt.q   = {s_r.q[30:0], 1'b1};
      end else begin
        s_nxt.rem = rem_sh[15:0];
        s_nxt.q   = {s_r.q[30:0], 1'b0};
      end
      s_nxt.cnt = s_r.cnt + 6'h01;
      if (s_r.cnt == 6'h1f) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign quotient = s_r.q;
  assign done     = s_r.done;
endmodule : div_unit

/* verilog/avg_ram.sv */
// Sample history for the moving-average filter, 1024 x 16.
// Assumes one write port and one read port; read data is registered.
module avg_ram (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        we,
  input  wire logic [9:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [9:0]  raddr,
  output logic      [15:0] rdata
);
  logic [15:0] mem [1024];

  // Array kept reset-free so it maps onto block memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : avg_ram

/* verilog/accel_decel_profile_gen.sv */
// Speed-profile generator: APB parameter registers, per-ms profile engine.
// Assumes APB master on pclk; cmd_speed feeds the motion stage directly.
module accel_decel_profile_gen #(
  parameter int TICK_LEN = profile_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] cmd_speed,
  output logic             moving
);
  import profile_pkg::*;

  typedef struct packed {
    params_s     cfg;
    params_s     run;
    gen_state_e  st;
    logic [15:0] tick_cnt;
    logic        busy;
    logic        decel;
    logic        div_wait;
    logic [1:0]  sub;
    logic [31:0] rate1;
    logic [31:0] rate2;
    logic [31:0] rated;
    logic [31:0] raw;
    logic [31:0] sum;
    logic [9:0]  wptr;
    logic [10:0] fill;
    logic [15:0] out;
  } gen_s;

  gen_s        s_r;
  gen_s        s_nxt;
  logic        apb_acc;
  logic        apb_wr;
  logic        mapped;
  logic        tick;
  logic        start_cmd;
  logic        stop_cmd;
  logic        div_go;
  logic [31:0] div_dvd;
  logic [15:0] div_dvs;
  logic [31:0] div_q;
  logic        div_done;
  logic        ram_we;
  logic [9:0]  ram_raddr;
  logic [15:0] ram_rdata;
  logic [15:0] tgt_eff;
  logic [31:0] tgt_fx;
  logic [31:0] sw_fx;
  logic [31:0] bias_fx;
  logic [31:0] goal;
  logic [31:0] diff;
  logic [31:0] step;
  logic [32:0] up33;
  logic [31:0] raw_lin;
  logic [31:0] raw_exp;
  logic [10:0] ma_n;
  logic [15:0] ma_old;
  logic [31:0] new_sum;
  logic        exp_mode;
  logic        ma_mode;

  // Plain combinational decode of the latched move parameters
  always_comb begin
    exp_mode = (s_r.run.filter_select_code == FILT_EXP) ||
               (s_r.run.filter_select_code == FILT_EXP_BIAS);
    ma_mode  = (s_r.run.filter_select_code == FILT_MAVG);
    // Target above the speed limit is clipped to the limit
    tgt_eff  = (s_r.run.target_speed > s_r.run.max_speed_limit) ?
               s_r.run.max_speed_limit : s_r.run.target_speed;
    tgt_fx   = {tgt_eff, 16'h0000};
    sw_fx    = {s_r.run.step_change_speed, 16'h0000};
    // Bias only counts in the biased mode, so zero bias equals plain
    bias_fx  = (s_r.run.filter_select_code == FILT_EXP_BIAS) ?
               {s_r.run.bias_speed, 16'h0000} : 32'h00000000;
    // Averaging window in ticks, 1 to 1024
    if (s_r.run.moving_avg_time_constant == 16'h0000) begin
      ma_n = 11'h001;
    end else if (s_r.run.moving_avg_time_constant > {5'h00, MA_DEPTH}) begin
      ma_n = MA_DEPTH;
    end else begin
      ma_n = s_r.run.moving_avg_time_constant[10:0];
    end
    ram_raddr = s_r.wptr - ma_n[9:0];
    ma_old    = (s_r.fill >= ma_n) ? ram_rdata : 16'h0000;
    new_sum   = s_r.sum + {16'h0000, s_r.raw[31:16]} - {16'h0000, ma_old};
  end

  // Linear ramp step for one tick, rate chosen by ramp code
  always_comb begin
    step    = s_r.rate1;
    up33    = 33'h000000000;
    raw_lin = s_r.raw;
    if (!s_r.decel) begin
      if (s_r.run.ramp_type_code == RAMP_DOUBLE && s_r.raw >= sw_fx) begin
        step = s_r.rate2;
      end
      up33 = {1'b0, s_r.raw} + {1'b0, step};
      if (s_r.run.ramp_type_code == RAMP_NONE ||
          up33 >= {1'b0, tgt_fx}) begin
        raw_lin = tgt_fx;
      end else begin
        raw_lin = up33[31:0];
      end
    end else begin
      if (s_r.run.ramp_type_code == RAMP_ASYM) begin
        step = s_r.rated;
      end else if (s_r.run.ramp_type_code == RAMP_DOUBLE &&
                   s_r.raw > sw_fx) begin
        step = s_r.rate2;
      end
      if (s_r.run.ramp_type_code == RAMP_NONE || s_r.raw <= step) begin
        raw_lin = 32'h00000000;
      end else begin
        raw_lin = s_r.raw - step;
      end
    end
  end

  // Exponential step: close gap to goal by gap / time constant per tick.
  // Over tau ticks this leaves about 1/e of the gap, i.e. 63.2 % covered.
  always_comb begin
    goal = s_r.decel ? bias_fx : tgt_fx;
    diff = (s_r.raw >= goal) ? s_r.raw - goal : goal - s_r.raw;
    if (div_q == 32'h00000000 || div_q >= diff) begin
      raw_exp = goal;
    end else if (s_r.raw >= goal) begin
      raw_exp = s_r.raw - div_q;
    end else begin
      raw_exp = s_r.raw + div_q;
    end
    // Once settled on the bias while stopping, drop straight to zero
    if (s_r.decel && raw_exp == goal) begin
      raw_exp = 32'h00000000;
    end
  end

  // APB decode; zero wait states, unmapped offsets answer an error
  always_comb begin
    apb_acc = psel && penable;
    apb_wr  = apb_acc && pwrite;
    mapped  = (paddr <= OFF_SPEED) && (paddr[1:0] == 2'b00);
    prdata  = 32'h00000000;
    unique case (paddr)
      OFF_MODE:   prdata = {28'h0000000, s_r.cfg.filter_select_code,
                            s_r.cfg.ramp_type_code};
      OFF_TGT:    prdata = {16'h0000, s_r.cfg.target_speed};
      OFF_ACC:    prdata = {16'h0000, s_r.cfg.accel_time};
      OFF_DEC:    prdata = {16'h0000, s_r.cfg.decel_time};
      OFF_SWSPD:  prdata = {16'h0000, s_r.cfg.step_change_speed};
      OFF_ACC2:   prdata = {16'h0000, s_r.cfg.second_accel_time};
      OFF_EXPTC:  prdata = {16'h0000, s_r.cfg.exp_time_constant};
      OFF_BIAS:   prdata = {16'h0000, s_r.cfg.bias_speed};
      OFF_MATC:   prdata = {16'h0000, s_r.cfg.moving_avg_time_constant};
      OFF_MAX:    prdata = {16'h0000, s_r.cfg.max_speed_limit};
      OFF_STATUS: prdata = {30'h00000000, s_r.decel, s_r.busy};
      OFF_SPEED:  prdata = {16'h0000, s_r.out};
      default:    prdata = 32'h00000000;
    endcase
  end

  assign pready    = 1'b1;
  assign pslverr   = apb_acc && !mapped;
  assign cmd_speed = s_r.out;
  assign moving    = s_r.busy;

  // Next-state logic: registers, tick divider and profile sequencer
  always_comb begin
    s_nxt     = s_r;
    start_cmd = 1'b0;
    stop_cmd  = 1'b0;
    div_go    = 1'b0;
    div_dvd   = 32'h00000000;
    div_dvs   = 16'h0000;
    ram_we    = 1'b0;
    tick      = 1'b0;
    // Fixed control tick of one millisecond
    if (s_r.tick_cnt == 16'(TICK_LEN - 1)) begin
      s_nxt.tick_cnt = 16'h0000;
      tick           = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
    end
    // Register writes take effect at the access-phase edge
    if (apb_wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          start_cmd = pwdata[CTRL_START_BIT];
          stop_cmd  = pwdata[CTRL_STOP_BIT];
        end
        OFF_MODE: begin
          s_nxt.cfg.ramp_type_code =
            ramp_e'(pwdata[MODE_RAMP_LSB +: 2]);
          s_nxt.cfg.filter_select_code =
            filt_e'(pwdata[MODE_FILT_LSB +: 2]);
        end
        OFF_TGT:   s_nxt.cfg.target_speed             = pwdata[15:0];
        OFF_ACC:   s_nxt.cfg.accel_time               = pwdata[15:0];
        OFF_DEC:   s_nxt.cfg.decel_time               = pwdata[15:0];
        OFF_SWSPD: s_nxt.cfg.step_change_speed        = pwdata[15:0];
        OFF_ACC2:  s_nxt.cfg.second_accel_time        = pwdata[15:0];
        OFF_EXPTC: s_nxt.cfg.exp_time_constant        = pwdata[15:0];
        OFF_BIAS:  s_nxt.cfg.bias_speed               = pwdata[15:0];
        OFF_MATC:  s_nxt.cfg.moving_avg_time_constant = pwdata[15:0];
        OFF_MAX:   s_nxt.cfg.max_speed_limit          = pwdata[15:0];
        default: begin
        end
      endcase
    end
    // Stop only matters during a move; it is never lost to a tick
    if (stop_cmd && s_r.busy) begin
      s_nxt.decel = 1'b1;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (start_cmd) begin
          s_nxt.run      = s_r.cfg;
          s_nxt.busy     = 1'b1;
          s_nxt.decel    = 1'b0;
          s_nxt.sub      = 2'h0;
          s_nxt.div_wait = 1'b0;
          s_nxt.sum      = 32'h00000000;
          s_nxt.fill     = 11'h000;
          s_nxt.wptr     = 10'h000;
          // Biased exponential starts from the bias speed at once
          s_nxt.raw = (s_r.cfg.filter_select_code == FILT_EXP_BIAS) ?
                      {s_r.cfg.bias_speed, 16'h0000} : 32'h00000000;
          s_nxt.st  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Rates in speed per ms: max/accel, (max-switch)/t2, max/decel
        unique case (s_r.sub)
          2'h0: begin
            div_dvd = {s_r.run.max_speed_limit, 16'h0000};
            div_dvs = s_r.run.accel_time;
          end
          2'h1: begin
            div_dvd = (s_r.run.max_speed_limit > sw_fx[31:16]) ?
                      {16'(s_r.run.max_speed_limit - sw_fx[31:16]),
                       16'h0000} : 32'h00000000;
            div_dvs = s_r.run.second_accel_time;
          end
          default: begin
            div_dvd = {s_r.run.max_speed_limit, 16'h0000};
            div_dvs = s_r.run.decel_time;
          end
        endcase
        if (!s_r.div_wait) begin
          div_go         = 1'b1;
          s_nxt.div_wait = 1'b1;
        end else if (div_done) begin
          s_nxt.div_wait = 1'b0;
          s_nxt.sub      = s_r.sub + 2'h1;
          unique case (s_r.sub)
            2'h0:    s_nxt.rate1 = div_q;
            2'h1:    s_nxt.rate2 = div_q;
            default: begin
              s_nxt.rated = div_q;
              s_nxt.st    = ST_WAIT;
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (exp_mode) begin
            s_nxt.st = ST_EXP;
          end else begin
            s_nxt.raw = raw_lin;
            if (ma_mode) begin
              s_nxt.st = ST_MARD;
            end else begin
              s_nxt.out = raw_lin[31:16];
              if (s_r.decel && raw_lin == 32'h00000000) begin
                s_nxt.busy = 1'b0;
                s_nxt.st   = ST_IDLE;
              end
            end
          end
        end
      end
      ST_EXP: begin
        div_dvd = diff;
        div_dvs = s_r.run.exp_time_constant;
        if (!s_r.div_wait) begin
          div_go         = 1'b1;
          s_nxt.div_wait = 1'b1;
        end else if (div_done) begin
          s_nxt.div_wait = 1'b0;
          s_nxt.raw      = raw_exp;
          s_nxt.out      = raw_exp[31:16];
          s_nxt.st       = ST_WAIT;
          if (s_r.decel && raw_exp == 32'h00000000) begin
            s_nxt.busy = 1'b0;
            s_nxt.st   = ST_IDLE;
          end
        end
      end
      ST_MARD: begin
        // History read issued now, data ready next cycle
        s_nxt.st = ST_MADIV;
      end
      ST_MADIV: begin
        // Running sum over the window rounds every corner of the ramp
        div_dvd = new_sum;
        div_dvs = {5'h00, ma_n};
        if (!s_r.div_wait) begin
          ram_we         = 1'b1;
          div_go         = 1'b1;
          s_nxt.div_wait = 1'b1;
          s_nxt.sum      = new_sum;
          s_nxt.wptr     = s_r.wptr + 10'h001;
          if (s_r.fill < ma_n) begin
            s_nxt.fill = s_r.fill + 11'h001;
          end
        end else if (div_done) begin
          s_nxt.div_wait = 1'b0;
          s_nxt.out      = div_q[15:0];
          s_nxt.st       = ST_WAIT;
          // Move ends only when the averaged output has settled to zero
          if (s_r.decel && s_r.raw == 32'h00000000 &&
              s_r.sum == 32'h00000000) begin
            s_nxt.busy = 1'b0;
            s_nxt.st   = ST_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // Whole state resets to zero: idle, parameters zero, speed zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  div_unit u_div (
    .clk      (pclk),
    .rst_n    (presetn),
    .start    (div_go),
    .dividend (div_dvd),
    .divisor  (div_dvs),
    .quotient (div_q),
    .done     (div_done)
  );

  avg_ram u_hist (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (ram_we),
    .waddr (s_r.wptr),
    .wdata (s_r.raw[31:16]),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );
endmodule : accel_decel_profile_gen

/* tb/profile_gen_asserts.sv */
// Checker for the profile generator; sees the top ports only.
// Assumes it is bound from the bench top and one pclk domain.
module profile_gen_asserts
  import profile_pkg::*;
#(
  parameter int TICK_LEN = 100
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] cmd_speed,
  input wire logic        moving
);
  logic        acc;
  logic        st;
  logic        bad;
  logic [15:0] spd_q;
  logic [15:0] gap_r;
  // Access phase, start write and unmapped decode
  assign acc = psel && penable;
  assign st  = acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_START_BIT];
  assign bad = paddr > OFF_SPEED || paddr[1:0] != 2'h0;
  // Cycles since the last speed change, saturating so idle is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_q <= 16'h0;
      gap_r <= 16'hffff;
    end else begin
      spd_q <= cmd_speed;
      if (cmd_speed != spd_q) gap_r <= 16'h0;
      else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; pready; endproperty
  property p_tick; cmd_speed != spd_q |-> gap_r >= TICK_LEN - 2; endproperty
  property p_start; st && !moving |=> moving [*2]; endproperty
  property p_idle; !moving && !st |=> !moving; endproperty
  property p_stop0; !moving |-> cmd_speed == 16'h0; endproperty
  // Moving may only drop with the speed at zero, on or after the edge that brings it there
  property p_hold;
    moving && cmd_speed != 16'h0 |=> moving || cmd_speed == 16'h0;
  endproperty
  property p_rdspd;
    acc && !pwrite && paddr == OFF_SPEED |-> prdata == {16'h0, cmd_speed};
  endproperty
  property p_unmap; acc && bad |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_map; acc && !bad |-> !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  a_tick: assert property (p_tick) else $error("early speed step");
  a_start: assert property (p_start) else $error("start lost");
  a_idle: assert property (p_idle) else $error("moving rose");
  a_stop0: assert property (p_stop0) else $error("idle speed");
  a_hold: assert property (p_hold) else $error("moving fell");
  a_rdspd: assert property (p_rdspd) else $error("speed read");
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  a_map: assert property (p_map) else $error("mapped err");
  // Main scenarios reached
  c_start: cover property (st && !moving);
  c_end: cover property ($fell(moving));
  c_err: cover property (acc && pslverr);
endmodule : profile_gen_asserts

/* tb/stage_model.sv */
// Motion stage model: follows the commanded speed, keeps its peak.
// Assumes cmd_speed in kilo-steps/min, stepped once per tick.
module stage_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] cmd_speed,
  output logic     [15:0] peak
);
  // Peak speed seen; a stage never exceeds what it is told
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) peak <= 16'h0;
    else if (cmd_speed > peak) peak <= cmd_speed;
  end
endmodule : stage_model

/* tb/accel_decel_profile_gen_tb.sv */
// Bench for the profile generator: APB host tasks, stage model.
// Assumes short tick (TK cycles) so every ms is TK pclk cycles.
module accel_decel_profile_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import profile_pkg::*;
  localparam int TK = 100;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        moving, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cmd_speed, peak;
  int          error_cnt, checks_done;
  accel_decel_profile_gen #(.TICK_LEN(TK)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_speed(cmd_speed), .moving(moving));
  stage_model u_stage (.pclk(pclk), .presetn(presetn),
    .cmd_speed(cmd_speed), .peak(peak));
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; pready is waited for, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Reset values, read-only places, unmapped and misaligned offsets
  task automatic regs_test();
    for (int a = 4; a <= 48; a += 4) begin
      apb(1'b0, a[7:0], 32'h0); chk(rd, 32'h0);
    end
    apb(1'b1, OFF_TGT, 32'hffff_abcd);
    apb(1'b0, OFF_TGT, 32'h0); chk(rd, 32'h0000_abcd);
    apb(1'b1, OFF_STATUS, 32'h3);
    apb(1'b0, OFF_STATUS, 32'h0); chk(rd, 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h34, 32'h0); chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h06, 32'h5); chk({31'h0, er}, 32'h1);
  endtask : regs_test
  // Start, sample k ticks after first step, hold, latch, stop and time it
  task automatic move(input logic [3:0] md, input logic [15:0] tg,
                      input int k, input int lo, input int hi, input int dn);
    int n;
    apb(1'b1, OFF_MODE, {28'h0, md});
    apb(1'b1, OFF_TGT, {16'h0, tg});
    apb(1'b1, OFF_CTRL, 32'h1);
    n = 0;
    while (cmd_speed === 16'h0 && n < 10 * TK) begin
      @(posedge pclk);
      n++;
    end
    repeat (k * TK + TK / 2) @(posedge pclk);
    chk({31'h0, cmd_speed >= lo && cmd_speed <= hi}, 32'h1);
    // Exponential tails only settle after some fifty ticks
    n = 0;
    while (cmd_speed !== tg && n < 80 * TK) begin
      @(posedge pclk);
      n++;
    end
    chk({16'h0, cmd_speed}, {16'h0, tg});
    apb(1'b0, OFF_SPEED, 32'h0); chk(rd, {16'h0, tg});
    apb(1'b1, OFF_TGT, {16'h0, tg + 16'h14});
    repeat (3 * TK) @(posedge pclk);
    chk({16'h0, cmd_speed}, {16'h0, tg});
    apb(1'b0, OFF_STATUS, 32'h0); chk(rd, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h2);
    n = 0;
    while (moving === 1'b1 && n < 80 * TK) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, moving}, 32'h0);
    if (dn > 0)
      chk({31'h0, n >= (dn - 1) * TK - 5 && n <= dn * TK + TK / 2},
          32'h1);
    repeat (2) @(posedge pclk);
  endtask : move
  task automatic complete_run();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Main sequence; mode nibble is filter code then ramp code
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; error_cnt = 0; checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs_test();
    apb(1'b1, OFF_MAX, 32'd100); apb(1'b1, OFF_ACC, 32'd10);
    apb(1'b1, OFF_DEC, 32'd5); apb(1'b1, OFF_SWSPD, 32'd20);
    apb(1'b1, OFF_ACC2, 32'd20); apb(1'b1, OFF_EXPTC, 32'd4);
    apb(1'b1, OFF_MATC, 32'd4); apb(1'b1, OFF_BIAS, 32'd20);
    move(4'h0, 16'd40, 0, 40, 40, 1);
    move(4'h1, 16'd40, 2, 30, 30, 4);
    move(4'h1, 16'd80, 2, 30, 30, 0);
    move(4'h2, 16'd40, 3, 28, 28, 7);
    move(4'h3, 16'd40, 2, 30, 30, 2);
    move(4'h4, 16'd100, 3, 67, 69, 0);
    move(4'h8, 16'd100, 3, 73, 75, 0);
    move(4'hc, 16'd40, 2, 30, 30, 0);
    move(4'hc, 16'd80, 2, 60, 60, 0);
    move(4'hd, 16'd40, 2, 15, 15, 7);
    move(4'hf, 16'd40, 2, 15, 15, 5);
    apb(1'b1, OFF_BIAS, 32'h0);
    move(4'h8, 16'd100, 3, 67, 69, 0);
    chk({16'h0, peak}, 32'd100);
    complete_run();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule : accel_decel_profile_gen_tb

bind accel_decel_profile_gen profile_gen_asserts #(.TICK_LEN(TICK_LEN)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_speed(cmd_speed),
  .moving(moving));
